/* verilog/pif_cfg.svh */
// Register offsets, field positions, reset values for the peripheral interrupt flag block.
// Assumes a 32-bit AXI4-Lite bus; each register sits in the low byte of one aligned word.
`ifndef PIF_CFG_SVH
`define PIF_CFG_SVH

`define PIF_OFF_ENABLE_ONE 8'h00
`define PIF_OFF_ENABLE_TWO 8'h04
`define PIF_OFF_FLAGS_ONE 8'h08
`define PIF_OFF_FLAGS_TWO 8'h0C
`define PIF_OFF_CONTROL 8'h10
`define PIF_OFF_STATUS 8'h14

`define PIF_RST_BYTE 8'h00
`define PIF_MASK_ENABLE_ONE 8'h7F
`define PIF_MASK_ENABLE_TWO 8'hFD
`define PIF_MASK_FLAGS_ONE_RW 8'h4F
`define PIF_MASK_FLAGS_TWO 8'hFD

// Flags one
`define PIF_B_TIMER1 0
`define PIF_B_TIMER2 1
`define PIF_B_CAPTURE1 2
`define PIF_B_SYNC 3
`define PIF_B_TX_EMPTY 4
`define PIF_B_RX_FULL 5
`define PIF_B_CONV_DONE 6
// Flags two
`define PIF_B_CAPTURE2 0
`define PIF_B_WAKE 2
`define PIF_B_BUS_COLL 3
`define PIF_B_NV_WRITE 4
`define PIF_B_COMP1 5
`define PIF_B_COMP2 6
`define PIF_B_OSC_FAIL 7
// Control register
`define PIF_B_PERIPH_EN 0
`define PIF_B_GLOBAL_EN 1

`define PIF_RESP_OKAY 2'b00
`define PIF_RESP_SLVERR 2'b10

`endif

/* verilog/pif_pkg.sv */
// Types for the peripheral interrupt flag block.
// Assumes pif_cfg.svh is compiled alongside.
package pif_pkg;

  typedef enum logic [1:0] {
    PIF_CCP_CAPTURE = 2'b00,
    PIF_CCP_COMPARE = 2'b01,
    PIF_CCP_PWM = 2'b10,
    PIF_CCP_OFF = 2'b11
  } pif_ccp_mode_t;

  typedef enum logic [1:0] {
    PIF_SSP_SPI = 2'b00,
    PIF_SSP_I2C_SLAVE = 2'b01,
    PIF_SSP_I2C_MASTER = 2'b10,
    PIF_SSP_OFF = 2'b11
  } pif_ssp_mode_t;

  typedef struct packed {
    logic [7:0] enable_one;
    logic [7:0] enable_two;
    logic [7:0] flags_one;
    logic [7:0] flags_two;
    logic periph_en;
    logic global_en;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_strb0;
    logic irq_req;
    logic rx_read;
    logic tx_write;
  } pif_state_t;

endpackage

/* verilog/pif_core.sv */
// Peripheral interrupt flag and enable registers with AXI4-Lite slave access.
// Assumes event inputs are one-cycle pulses synchronous to clock; the uart
// status levels come straight from the serial port.
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pif_cfg.svh"

// Summary of operation
// - No request unless peripheral enable set
// - Flags set regardless of any enable
// - Enable-two bit layout, set bit enables
// - Bit 1 of enable/flags two reads zero
// - Flags-one bit 7 reads zero
// - Conversion done sets sticky flag bit 6
// - Rx flag follows buffer full, read-only
// - Tx flag follows buffer empty, read-only
// - Serial transfer sets sticky flag bit 3
// - I2C master sequence completion sets flag
// - Idle start/stop in multi-master sets flag
// - Capture one: capture/compare sets, PWM unused
// - Timer2 period match sets flag bit 1
// - Timer1 overflow sets flag bit 0
// - Oscillator failure sets flags-two bit 7
// - I2C master bus collision sets bit 3
// - Low-power wake-up sets bit 2
// - Capture two: capture/compare sets, PWM unused
// - Global enable passes or blocks everything
// - Peripheral enable passes or blocks peripherals
module pif_core (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic conv_done_evt,
  input wire logic uart_rx_full,
  input wire logic uart_tx_empty,
  input wire pif_pkg::pif_ssp_mode_t ssp_mode,
  input wire logic ssp_xfer_evt,
  input wire logic ssp_seq_done_evt,
  input wire logic ssp_idle_cond_evt,
  input wire logic multi_master,
  input wire logic ssp_collision_evt,
  input wire pif_pkg::pif_ccp_mode_t capture_unit1_mode,
  input wire logic capture_unit1_evt,
  input wire pif_pkg::pif_ccp_mode_t capture_unit2_mode,
  input wire logic capture_unit2_evt,
  input wire logic timer2_match_evt,
  input wire logic timer1_overflow_evt,
  input wire logic osc_fail_evt,
  input wire logic comparator1_evt,
  input wire logic comparator2_evt,
  input wire logic nv_write_done_evt,
  input wire logic lowpower_wake_evt,
  output logic periph_irq,
  output logic uart_rx_data_read,
  output logic uart_tx_data_write
);
  import pif_pkg::*;

  pif_state_t s_r;
  pif_state_t s_nxt;
  logic [7:0] set_one;
  logic [7:0] set_two;
  logic do_write;
  logic do_read;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic ccp_counts(input pif_ccp_mode_t mode, input logic evt);
    // In PWM mode the capture flag is not used at all
    ccp_counts = evt && (mode == PIF_CCP_CAPTURE || mode == PIF_CCP_COMPARE);
  endfunction

  function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [7:0] val,
                                        input logic [7:0] mask, input logic [7:0] setv);
    wr_byte = ((old & ~mask) | (val & mask)) | setv;
  endfunction

  // ****************************************
  // Event collection
  // ****************************************
  always_comb begin
    set_one = 8'h00;
    set_one[`PIF_B_CONV_DONE] = conv_done_evt;
    set_one[`PIF_B_SYNC] = (ssp_xfer_evt && ssp_mode != PIF_SSP_OFF)
      || (ssp_seq_done_evt && ssp_mode == PIF_SSP_I2C_MASTER)
      || (ssp_idle_cond_evt && multi_master && ssp_mode != PIF_SSP_OFF);
    set_one[`PIF_B_CAPTURE1] = ccp_counts(capture_unit1_mode, capture_unit1_evt);
    set_one[`PIF_B_TIMER2] = timer2_match_evt;
    set_one[`PIF_B_TIMER1] = timer1_overflow_evt;
    set_two = 8'h00;
    set_two[`PIF_B_OSC_FAIL] = osc_fail_evt;
    set_two[`PIF_B_COMP2] = comparator2_evt;
    set_two[`PIF_B_COMP1] = comparator1_evt;
    set_two[`PIF_B_NV_WRITE] = nv_write_done_evt;
    set_two[`PIF_B_BUS_COLL] = ssp_collision_evt && ssp_mode == PIF_SSP_I2C_MASTER;
    set_two[`PIF_B_WAKE] = lowpower_wake_evt;
    set_two[`PIF_B_CAPTURE2] = ccp_counts(capture_unit2_mode, capture_unit2_evt);
  end

  // ****************************************
  // Bus handshake
  // ****************************************
  // Address and data may arrive in either order; each is latched until both are held
  // Ready and valid are withheld while frozen, so no beat is accepted and then lost
  assign s_axi_awready = clk_en && !s_r.aw_held && !s_r.bvalid;
  assign s_axi_wready = clk_en && !s_r.w_held && !s_r.bvalid;
  assign s_axi_arready = clk_en && !s_r.rvalid;
  assign do_write = s_r.aw_held && s_r.w_held && !s_r.bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.rx_read = 1'b0;
    s_nxt.tx_write = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_held = 1'b1;
      s_nxt.w_data = s_axi_wdata[7:0];
      s_nxt.w_strb0 = s_axi_wstrb[0];
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    // Hardware sets are ORed in after the write so an event never loses to a clear
    s_nxt.flags_one = s_r.flags_one | set_one;
    s_nxt.flags_two = s_r.flags_two | set_two;
    if (do_write) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `PIF_RESP_OKAY;
      unique case (s_r.aw_addr)
        `PIF_OFF_ENABLE_ONE: begin
          if (s_r.w_strb0) s_nxt.enable_one = s_r.w_data & `PIF_MASK_ENABLE_ONE;
        end
        `PIF_OFF_ENABLE_TWO: begin
          if (s_r.w_strb0) s_nxt.enable_two = s_r.w_data & `PIF_MASK_ENABLE_TWO;
        end
        `PIF_OFF_FLAGS_ONE: begin
          if (s_r.w_strb0) begin
            s_nxt.flags_one = wr_byte(s_r.flags_one, s_r.w_data, `PIF_MASK_FLAGS_ONE_RW, set_one);
          end
        end
        `PIF_OFF_FLAGS_TWO: begin
          if (s_r.w_strb0) begin
            s_nxt.flags_two = wr_byte(s_r.flags_two, s_r.w_data, `PIF_MASK_FLAGS_TWO, set_two);
          end
        end
        `PIF_OFF_CONTROL: begin
          if (s_r.w_strb0) begin
            s_nxt.periph_en = s_r.w_data[`PIF_B_PERIPH_EN];
            s_nxt.global_en = s_r.w_data[`PIF_B_GLOBAL_EN];
          end
        end
        `PIF_OFF_STATUS: begin
          // Data registers of the serial port are mapped here only as side-effect strobes
          if (s_r.w_strb0) s_nxt.tx_write = 1'b1;
        end
        default: begin
          s_nxt.bresp = `PIF_RESP_SLVERR;
        end
      endcase
    end
    // Status bits of the serial port are live levels, never stored by software
    s_nxt.flags_one[`PIF_B_RX_FULL] = uart_rx_full;
    s_nxt.flags_one[`PIF_B_TX_EMPTY] = uart_tx_empty;
    s_nxt.flags_one[7] = 1'b0;
    s_nxt.flags_two[1] = 1'b0;
    if (do_read) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `PIF_RESP_OKAY;
      s_nxt.rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        `PIF_OFF_ENABLE_ONE: s_nxt.rdata[7:0] = s_r.enable_one;
        `PIF_OFF_ENABLE_TWO: s_nxt.rdata[7:0] = s_r.enable_two;
        `PIF_OFF_FLAGS_ONE: s_nxt.rdata[7:0] = s_r.flags_one;
        `PIF_OFF_FLAGS_TWO: s_nxt.rdata[7:0] = s_r.flags_two;
        `PIF_OFF_CONTROL: begin
          s_nxt.rdata[`PIF_B_PERIPH_EN] = s_r.periph_en;
          s_nxt.rdata[`PIF_B_GLOBAL_EN] = s_r.global_en;
        end
        `PIF_OFF_STATUS: begin
          // Reading here stands for reading the receive data register
          s_nxt.rdata[0] = s_r.irq_req;
          s_nxt.rx_read = 1'b1;
        end
        default: s_nxt.rresp = `PIF_RESP_SLVERR;
      endcase
    end
    // Software is expected to clear a flag before enabling it; a stale one fires at once
    s_nxt.irq_req = s_r.global_en && s_r.periph_en
      && (|(s_r.flags_one & s_r.enable_one) || |(s_r.flags_two & s_r.enable_two));
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_bvalid = s_r.bvalid && clk_en;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_rvalid = s_r.rvalid && clk_en;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign periph_irq = s_r.irq_req;
  assign uart_rx_data_read = s_r.rx_read;
  assign uart_tx_data_write = s_r.tx_write;

  // ****************************************
  // Checks
  // ****************************************
  a_no_irq_wo_periph: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && !s_r.periph_en) |-> ##1 !periph_irq) else $error("request without peripheral enable");
  a_no_irq_wo_global: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && !s_r.global_en) |-> ##1 !periph_irq) else $error("request without global enable");
  a_irq_follows_flag: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && s_r.global_en && s_r.periph_en && |(s_r.flags_two & s_r.enable_two)) |=> periph_irq)
    else $error("enabled flag gave no request");
  a_flag_conv_sets: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && conv_done_evt) |=> s_r.flags_one[`PIF_B_CONV_DONE]) else $error("conversion flag not set");
  a_flag_two_sets: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && osc_fail_evt) |=> s_r.flags_two[`PIF_B_OSC_FAIL]) else $error("osc fail flag not set");
  a_unimpl_zero: assert property (@(posedge clock) disable iff (sys_rst)
    !s_r.flags_two[1] && !s_r.enable_two[1] && !s_r.flags_one[7]) else $error("unimplemented bit set");
  a_rx_level: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en |=> s_r.flags_one[`PIF_B_RX_FULL] == $past(uart_rx_full)) else $error("rx flag mismatch");
  a_pwm_ignored: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && capture_unit1_mode == PIF_CCP_PWM && !s_r.flags_one[2] && !do_write) |=> !s_r.flags_one[2])
    else $error("capture flag set in pwm");
  a_set_beats_clear: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && timer1_overflow_evt) |=> s_r.flags_one[`PIF_B_TIMER1]) else $error("event lost to clear");

  // ****************************************
  // Checks on each event source
  // ****************************************
  // Software writes to a flag register, the only way a stored flag may drop
  logic wr_flags_one;
  logic wr_flags_two;
  assign wr_flags_one = do_write && s_r.w_strb0 && s_r.aw_addr == `PIF_OFF_FLAGS_ONE;
  assign wr_flags_two = do_write && s_r.w_strb0 && s_r.aw_addr == `PIF_OFF_FLAGS_TWO;
  a_sync_xfer_sets: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && ssp_xfer_evt && ssp_mode != PIF_SSP_OFF) |=> s_r.flags_one[`PIF_B_SYNC])
    else $error("transfer flag not set");
  a_sync_seq_sets: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && ssp_seq_done_evt && ssp_mode == PIF_SSP_I2C_MASTER) |=> s_r.flags_one[`PIF_B_SYNC])
    else $error("sequence flag not set");
  a_sync_idle_sets: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && ssp_idle_cond_evt && multi_master && ssp_mode != PIF_SSP_OFF) |=> s_r.flags_one[`PIF_B_SYNC])
    else $error("idle condition flag not set");
  a_cap1_sets: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && capture_unit1_evt && (capture_unit1_mode == PIF_CCP_CAPTURE || capture_unit1_mode == PIF_CCP_COMPARE))
    |=> s_r.flags_one[`PIF_B_CAPTURE1]) else $error("capture one flag not set");
  a_timer2_sets: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && timer2_match_evt) |=> s_r.flags_one[`PIF_B_TIMER2])
    else $error("timer two flag not set");
  a_comp2_sets: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && comparator2_evt) |=> s_r.flags_two[`PIF_B_COMP2])
    else $error("comparator two flag not set");
  a_comp1_sets: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && comparator1_evt) |=> s_r.flags_two[`PIF_B_COMP1])
    else $error("comparator one flag not set");
  a_nv_write_sets: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && nv_write_done_evt) |=> s_r.flags_two[`PIF_B_NV_WRITE])
    else $error("memory write flag not set");
  a_bus_coll_sets: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && ssp_collision_evt && ssp_mode == PIF_SSP_I2C_MASTER) |=> s_r.flags_two[`PIF_B_BUS_COLL])
    else $error("collision flag not set");
  a_wake_sets: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && lowpower_wake_evt) |=> s_r.flags_two[`PIF_B_WAKE])
    else $error("wake flag not set");
  a_cap2_sets: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && capture_unit2_evt && (capture_unit2_mode == PIF_CCP_CAPTURE || capture_unit2_mode == PIF_CCP_COMPARE))
    |=> s_r.flags_two[`PIF_B_CAPTURE2]) else $error("capture two flag not set");
  a_sync_off_quiet: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && ssp_mode == PIF_SSP_OFF && !s_r.flags_one[`PIF_B_SYNC] && !wr_flags_one)
    |=> !s_r.flags_one[`PIF_B_SYNC]) else $error("serial flag set while port off");
  a_coll_master_only: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && ssp_mode != PIF_SSP_I2C_MASTER && !s_r.flags_two[`PIF_B_BUS_COLL] && !wr_flags_two)
    |=> !s_r.flags_two[`PIF_B_BUS_COLL]) else $error("collision flag set outside master mode");

  // ****************************************
  // Checks on stored and live flags and on the serial port strobes
  // ****************************************
  // A stored flag only drops on a software write to its register
  a_cap2_pwm_quiet: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && capture_unit2_mode == PIF_CCP_PWM && !s_r.flags_two[`PIF_B_CAPTURE2] && !wr_flags_two)
    |=> !s_r.flags_two[`PIF_B_CAPTURE2]) else $error("capture two flag set in pwm");
  a_tx_level: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en |=> s_r.flags_one[`PIF_B_TX_EMPTY] == $past(uart_tx_empty))
    else $error("tx flag mismatch");
  a_conv_sticky: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && s_r.flags_one[`PIF_B_CONV_DONE] && !wr_flags_one) |=> s_r.flags_one[`PIF_B_CONV_DONE])
    else $error("conversion flag dropped");
  a_osc_sticky: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && s_r.flags_two[`PIF_B_OSC_FAIL] && !wr_flags_two) |=> s_r.flags_two[`PIF_B_OSC_FAIL])
    else $error("osc fail flag dropped");
  a_wake_sticky: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && s_r.flags_two[`PIF_B_WAKE] && !wr_flags_two) |=> s_r.flags_two[`PIF_B_WAKE])
    else $error("wake flag dropped");
  a_timer2_sticky: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && s_r.flags_one[`PIF_B_TIMER2] && !wr_flags_one) |=> s_r.flags_one[`PIF_B_TIMER2])
    else $error("timer two flag dropped");
  a_sync_sticky: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && s_r.flags_one[`PIF_B_SYNC] && !wr_flags_one) |=> s_r.flags_one[`PIF_B_SYNC])
    else $error("serial flag dropped");
  a_write_clears: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && wr_flags_one && !s_r.w_data[`PIF_B_TIMER1] && !timer1_overflow_evt)
    |=> !s_r.flags_one[`PIF_B_TIMER1]) else $error("write of zero did not clear");
  a_rx_pulse: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && do_read && s_axi_araddr == `PIF_OFF_STATUS) |=> uart_rx_data_read)
    else $error("no receive read strobe");
  a_tx_pulse: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && do_write && s_r.w_strb0 && s_r.aw_addr == `PIF_OFF_STATUS) |=> uart_tx_data_write)
    else $error("no transmit write strobe");

  // ****************************************
  // Checks on the request
  // ****************************************
  a_irq_one_flag: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && s_r.global_en && s_r.periph_en && |(s_r.flags_one & s_r.enable_one)) |=> periph_irq)
    else $error("enabled flag one gave no request");
  a_no_irq_unmasked: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && !(|(s_r.flags_one & s_r.enable_one)) && !(|(s_r.flags_two & s_r.enable_two))) |=> !periph_irq)
    else $error("request with no enabled flag");

  // ****************************************
  // Coverage
  // ****************************************
  // Freeze and set-with-clear are the corners that tests reach least
  c_irq_raised: cover property (@(posedge clock) disable iff (sys_rst) $rose(periph_irq));
  c_write_done: cover property (@(posedge clock) disable iff (sys_rst) s_axi_bvalid && s_axi_bready);
  c_read_done: cover property (@(posedge clock) disable iff (sys_rst) s_axi_rvalid && s_axi_rready);
  c_set_with_clear: cover property (@(posedge clock) disable iff (sys_rst)
    clk_en && wr_flags_one && timer1_overflow_evt);
  c_frozen_event: cover property (@(posedge clock) disable iff (sys_rst)
    !clk_en && ((|set_one) || (|set_two)));

endmodule // pif_core

/* test/pif_src_model.sv */
// Model of the event sources and serial port beside the peripheral flag block.
// Assumes bench commands change just after a rising edge of clock.
`timescale 1ns/1ps
module pif_src_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [13:0] fire,
  input wire logic rx_load,
  input wire logic tx_load,
  input wire logic rx_taken,
  input wire logic tx_taken,
  output logic [13:0] evt,
  output logic rx_full,
  output logic tx_empty
);
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      evt <= 14'h0000;
      rx_full <= 1'b0;
      tx_empty <= 1'b0;
    end else begin
      // Peripherals report each event as a single-cycle pulse
      evt <= fire;
      rx_full <= rx_load | (rx_full & ~rx_taken);
      tx_empty <= tx_load | (tx_empty & ~tx_taken);
    end
  end
endmodule // pif_src_model

/* test/peripheral_irq_flags_enables_tb_top.sv */
// Self-checking bench for the peripheral flag block, with a flag model in logic bits.
// Assumes pif_cfg.svh, pif_pkg and pif_core are compiled first.
`timescale 1ns/1ps
module peripheral_irq_flags_enables_tb_top;
  import pif_pkg::*;
  logic clock, sys_rst, clk_en, multi_master, rx_load, tx_load, rx_full, tx_empty, rx_rd, tx_wr, irq;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, mrx, mtx;
  logic [7:0] awaddr, araddr, e1, e2, ctl;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [13:0] fire, evt;
  logic [15:0] mf;
  pif_ssp_mode_t ssp_mode;
  pif_ccp_mode_t cap1_mode, cap2_mode;
  int n_mismatch, cmp_count, cyc;
  int pos[14] = '{0, 1, 2, 3, 6, 8, 10, 11, 12, 13, 14, 15, 3, 3};
  logic [7:0] msk[4] = '{8'h7F, 8'hFD, 8'h4F, 8'hFD};

  pif_core u_dut (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .conv_done_evt(evt[4]), .uart_rx_full(rx_full), .uart_tx_empty(tx_empty),
    .ssp_mode(ssp_mode), .ssp_xfer_evt(evt[3]), .ssp_seq_done_evt(evt[12]), .ssp_idle_cond_evt(evt[13]),
    .multi_master(multi_master), .ssp_collision_evt(evt[7]), .capture_unit1_mode(cap1_mode),
    .capture_unit1_evt(evt[2]), .capture_unit2_mode(cap2_mode), .capture_unit2_evt(evt[5]),
    .timer2_match_evt(evt[1]), .timer1_overflow_evt(evt[0]), .osc_fail_evt(evt[11]),
    .comparator1_evt(evt[9]), .comparator2_evt(evt[10]), .nv_write_done_evt(evt[8]),
    .lowpower_wake_evt(evt[6]), .periph_irq(irq), .uart_rx_data_read(rx_rd), .uart_tx_data_write(tx_wr));

  pif_src_model u_src (.clock(clock), .sys_rst(sys_rst), .fire(fire), .rx_load(rx_load), .tx_load(tx_load),
    .rx_taken(rx_rd), .tx_taken(tx_wr), .evt(evt), .rx_full(rx_full), .tx_empty(tx_empty));

  // ****************************************
  // Bus tasks and expected values
  // ****************************************
  task automatic final_report();
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  function automatic logic [7:0] x1();
    return {1'b0, mf[6], mrx, mtx, mf[3:0]};
  endfunction

  function automatic logic [7:0] x2();
    return {mf[15:10], 1'b0, mf[8]};
  endfunction

  function automatic logic xirq();
    return ctl[0] & ctl[1] & |{x1() & e1 & 8'h7F, x2() & e2 & 8'hFD};
  endfunction

  // A source outside the modes that report it raises nothing
  task automatic pulse(input logic [13:0] v);
    @(posedge clock);
    fire <= v;
    @(posedge clock);
    fire <= 14'h0000;
    for (int i = 0; i < 14; i++)
      if (v[i] && !(i == 2 && cap1_mode > 1) && !(i == 5 && cap2_mode > 1) && !(i == 3 && ssp_mode == PIF_SSP_OFF)
          && !((i == 7 || i == 12) && ssp_mode != PIF_SSP_I2C_MASTER)
          && !(i == 13 && (!multi_master || ssp_mode == PIF_SSP_OFF))) mf[pos[i]] = 1'b1;
    repeat (3) @(posedge clock);
  endtask

  task automatic check_all();
    rd(8'h08);
    chk(d, {24'h0, x1()});
    rd(8'h0C);
    chk(d, {24'h0, x2()});
    chk({31'h0, irq}, {31'h0, xirq()});
  endtask

  task automatic clr();
    wr(8'h08, 8'h00);
    wr(8'h0C, 8'h00);
    mf = 16'h0000;
  endtask

  // ****************************************
  // Clock, timeout and main sequence
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready, rx_load, tx_load, mrx, mtx} = '0;
    {awaddr, araddr, wdata, fire, mf, e1, e2, ctl} = '0;
    ssp_mode = PIF_SSP_I2C_MASTER;
    multi_master = 1'b1;
    cap1_mode = PIF_CCP_CAPTURE;
    cap2_mode = PIF_CCP_CAPTURE;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    void'($urandom(32'h7d041797));
    for (int a = 0; a < 6; a++) begin
      rd(8'(a * 4));
      chk(d, 32'h0);
    end
    for (int a = 0; a < 4; a++) begin
      wr(8'(a * 4), 8'hFF);
      rd(8'(a * 4));
      chk(d, {24'h0, msk[a]});
    end
    chk({31'h0, irq}, 32'h0);
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h00);
    clr();
    rd(8'h18);
    chk({30'h0, r}, 32'h2);
    chk(d, 32'h0);
    wr(8'h18, 8'hFF);
    chk({30'h0, r}, 32'h2);
    for (int i = 0; i < 14; i++) begin
      pulse(14'h1 << i);
      check_all();
      clr();
    end
    for (int m = 0; m < 3; m++) begin
      cap1_mode <= pif_ccp_mode_t'(m);
      cap2_mode <= pif_ccp_mode_t'(m);
      pulse(14'h0024);
      check_all();
      clr();
    end
    repeat (24) begin
      e1 = 8'($urandom);
      e2 = 8'($urandom);
      ctl = {6'h0, 2'($urandom)};
      cap1_mode <= pif_ccp_mode_t'(2'($urandom));
      cap2_mode <= pif_ccp_mode_t'(2'($urandom));
      ssp_mode <= pif_ssp_mode_t'(2'($urandom));
      multi_master <= 1'($urandom);
      wr(8'h00, e1);
      wr(8'h04, e2);
      wr(8'h10, ctl);
      pulse(14'($urandom));
      check_all();
      rd(8'h14);
      chk(d, {31'h0, xirq()});
      clr();
    end
    // Clearing write and a new event land at the same edge: the event must win
    fork
      wr(8'h08, 8'h00);
      begin
        @(posedge clock);
        fire <= 14'h0001;
        @(posedge clock);
        fire <= 14'h0000;
      end
    join
    mf[0] = 1'b1;
    check_all();
    clr();
    // Events while frozen are not recorded
    @(posedge clock);
    clk_en <= 1'b0;
    pulse(14'h3FFF);
    mf = 16'h0000;
    @(posedge clock);
    clk_en <= 1'b1;
    check_all();
    e1 = 8'h30;
    ctl = 8'h03;
    wr(8'h00, e1);
    wr(8'h10, ctl);
    @(posedge clock);
    rx_load <= 1'b1;
    tx_load <= 1'b1;
    @(posedge clock);
    rx_load <= 1'b0;
    tx_load <= 1'b0;
    {mrx, mtx} = 2'b11;
    clr();
    check_all();
    rd(8'h14);
    mrx = 1'b0;
    repeat (3) @(posedge clock);
    check_all();
    wr(8'h14, 8'h00);
    mtx = 1'b0;
    repeat (3) @(posedge clock);
    check_all();
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    for (int a = 0; a < 6; a++) begin
      rd(8'(a * 4));
      chk(d, 32'h0);
    end
    final_report();
  end
endmodule // peripheral_irq_flags_enables_tb_top
